//--- basic_mode_pkg.sv
/*
 Constants for the basic mode control register block: bit positions,
 reset values, bus decode and timing counts.
 Assumes a 100 MHz APB clock and a single register at byte address zero.
*/
package basic_mode_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Bit time at the fastest port speed
	localparam int unsigned BIT_TIME_NS = 10;
	localparam int unsigned COL_ASSERT_BIT_TIMES = 512;
	localparam int unsigned COL_DEASSERT_BIT_TIMES = 4;
	// Longest times round down, with no floor at one cycle
	localparam int unsigned COL_ASSERT_MAX_CYCLES =
		(COL_ASSERT_BIT_TIMES * BIT_TIME_NS) / CLK_PERIOD_NS;
	localparam int unsigned COL_DEASSERT_MAX_CYCLES =
		(COL_DEASSERT_BIT_TIMES * BIT_TIME_NS) / CLK_PERIOD_NS;
	// Cycles after reset release before straps are taken
	localparam logic [1:0] STRAP_WAIT = 2'h3;

	localparam logic [11:0] ADDR_BASIC_MODE_CONTROL = 12'h000;
	localparam int unsigned REG_W = 16;

	localparam int unsigned BIT_SPEED = 13;
	localparam int unsigned BIT_AN_ENABLE = 12;
	localparam int unsigned BIT_POWER_DOWN = 11;
	localparam int unsigned BIT_ISOLATE = 10;
	localparam int unsigned BIT_AN_RESTART = 9;
	localparam int unsigned BIT_DUPLEX = 8;
	localparam int unsigned BIT_COL_TEST = 7;
	localparam int unsigned BIT_UNIDIR = 5;

	localparam logic RST_POWER_DOWN = 1'b0;
	localparam logic RST_ISOLATE = 1'b0;
	localparam logic RST_AN_RESTART = 1'b0;
	localparam logic RST_COL_TEST = 1'b0;
	localparam logic RST_UNIDIR = 1'b0;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage : basic_mode_pkg

//--- pin_sync.sv
/*
 Two-flip-flop synchroniser for a vector of pin levels.
 Assumes levels, not pulses, and a constant reset value.
*/
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= RESET_VAL;
			sync_out <= RESET_VAL;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pin_sync

//--- col_test_gen.sv
/*
 Collision test generator: drives collision while transmit enable is
 seen in collision test mode.
 Assumes tx_en already synchronised to clk.
*/
`timescale 1ns/1ps
module col_test_gen (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic test_en,
	input wire logic tx_en,
	// Result
	output logic col
);
	// Registered so that collision follows transmit enable by one cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			col <= 1'b0;
		else
			col <= test_en & tx_en;
	end
endmodule : col_test_gen

//--- basic_mode_control.sv
/*
 Basic mode control register of a fast Ethernet transceiver, reached as
 an APB slave, with the mode outputs it steers toward the port logic.
 Assumes straps and the power down pin, transmit enable and link status
 are pins; negotiation handshake and results come from logic on pclk.
*/
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module basic_mode_control (
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Strap and control pins
	input wire logic strap_an_enable,
	input wire logic strap_speed_100,
	input wire logic strap_full_duplex,
	input wire logic fiber_mode_enable,
	input wire logic power_down_pin_n,
	// Port status pins
	input wire logic tx_en,
	input wire logic link_up,
	// Negotiation logic, same clock
	input wire logic an_started,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	output logic an_restart_req,
	// Mode outputs
	output logic an_enable,
	output logic speed_100,
	output logic full_duplex,
	output logic power_down,
	output logic isolate,
	output logic col,
	output logic tx_allowed
);
	localparam int unsigned REG_W_L = basic_mode_pkg::REG_W;

	logic [4:0] pins_sync;
	logic s_an, s_speed, s_duplex, s_fiber, s_pd_n;
	logic txen_sync, link_sync;
	logic [1:0] strap_cnt_q;
	logic strap_done_q;
	logic strap_load;
	logic speed_q, an_en_q, pd_q, iso_q, restart_q, duplex_q;
	logic col_test_q, unidir_q;
	logic access, wr_acc, rd_acc, hit;
	logic [REG_W_L-1:0] wdata;
	logic [REG_W_L-1:0] reg_val;
	logic restart_set;
	logic eff_speed, eff_duplex, eff_pd;
	logic col_raw;

	pin_sync #(
		.W(5),
		.RESET_VAL(5'h10)
	) u_strap_sync (
		.clk(pclk),
		.rst_n(presetn),
		.async_in({power_down_pin_n, fiber_mode_enable, strap_full_duplex,
			strap_speed_100, strap_an_enable}),
		.sync_out(pins_sync)
	);

	assign s_an = pins_sync[0];
	assign s_speed = pins_sync[1];
	assign s_duplex = pins_sync[2];
	assign s_fiber = pins_sync[3];
	assign s_pd_n = pins_sync[4];

	pin_sync #(
		.W(2),
		.RESET_VAL(2'h0)
	) u_port_sync (
		.clk(pclk),
		.rst_n(presetn),
		.async_in({link_up, tx_en}),
		.sync_out({link_sync, txen_sync})
	);

	// Straps are caught once the synchroniser holds real pin levels
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			strap_cnt_q <= 2'h0;
		else if (!strap_done_q)
			strap_cnt_q <= strap_cnt_q + 2'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			strap_done_q <= 1'b0;
		else if (strap_load)
			strap_done_q <= 1'b1;
	end

	assign strap_load = !strap_done_q &&
		(strap_cnt_q == basic_mode_pkg::STRAP_WAIT);

	// Bus decode; one wait state, nothing answered before straps load
	assign access = psel & penable & ~pready & strap_done_q;
	assign hit = (paddr == basic_mode_pkg::ADDR_BASIC_MODE_CONTROL);
	assign wr_acc = access & pwrite & hit;
	assign rd_acc = access & ~pwrite & hit;
	assign wdata = pwdata[REG_W_L-1:0];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= access;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= access & ~hit;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= basic_mode_pkg::RDATA_ZERO;
		else if (rd_acc)
			prdata <= {16'h0000, reg_val};
		else if (access)
			prdata <= basic_mode_pkg::RDATA_ZERO;
	end

	// Reserved bits 6 and 4:0 are never stored
	always_comb
	begin
		reg_val = '0;
		reg_val[basic_mode_pkg::BIT_SPEED] = speed_q;
		reg_val[basic_mode_pkg::BIT_AN_ENABLE] = an_en_q;
		reg_val[basic_mode_pkg::BIT_POWER_DOWN] = pd_q;
		reg_val[basic_mode_pkg::BIT_ISOLATE] = iso_q;
		reg_val[basic_mode_pkg::BIT_AN_RESTART] = restart_q;
		reg_val[basic_mode_pkg::BIT_DUPLEX] = duplex_q;
		reg_val[basic_mode_pkg::BIT_COL_TEST] = col_test_q;
		reg_val[basic_mode_pkg::BIT_UNIDIR] = unidir_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			an_en_q <= 1'b0;
		else if (strap_load)
			an_en_q <= s_an & ~s_fiber;
		else if (wr_acc)
			an_en_q <= wdata[basic_mode_pkg::BIT_AN_ENABLE];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			speed_q <= 1'b0;
		else if (strap_load)
			speed_q <= s_speed;
		else if (wr_acc)
			speed_q <= wdata[basic_mode_pkg::BIT_SPEED];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			duplex_q <= 1'b0;
		else if (strap_load)
			duplex_q <= s_duplex;
		else if (wr_acc)
			duplex_q <= wdata[basic_mode_pkg::BIT_DUPLEX];
	end

	// Pin set wins over a software clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pd_q <= basic_mode_pkg::RST_POWER_DOWN;
		else if (!s_pd_n)
			pd_q <= 1'b1;
		else if (wr_acc)
			pd_q <= wdata[basic_mode_pkg::BIT_POWER_DOWN];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			iso_q <= basic_mode_pkg::RST_ISOLATE;
		else if (wr_acc)
			iso_q <= wdata[basic_mode_pkg::BIT_ISOLATE];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			col_test_q <= basic_mode_pkg::RST_COL_TEST;
		else if (wr_acc)
			col_test_q <= wdata[basic_mode_pkg::BIT_COL_TEST];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			unidir_q <= basic_mode_pkg::RST_UNIDIR;
		else if (wr_acc)
			unidir_q <= wdata[basic_mode_pkg::BIT_UNIDIR];
	end

	// Restart counts only with enable in the same written word
	assign restart_set = wr_acc & wdata[basic_mode_pkg::BIT_AN_RESTART] &
		wdata[basic_mode_pkg::BIT_AN_ENABLE];

	// A new write of one beats the start acknowledge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			restart_q <= basic_mode_pkg::RST_AN_RESTART;
		else if (restart_set)
			restart_q <= 1'b1;
		else if (an_started)
			restart_q <= 1'b0;
		else if (wr_acc)
			restart_q <= 1'b0;
	end

	// No second request while one is still pending
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			an_restart_req <= 1'b0;
		else
			an_restart_req <= restart_set & ~restart_q;
	end

	// Negotiated results replace the forced bits while enabled
	assign eff_speed = an_en_q ? an_speed_100 : speed_q;
	assign eff_duplex = an_en_q ? an_full_duplex : duplex_q;
	assign eff_pd = pd_q | ~s_pd_n;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			an_enable <= 1'b0;
			speed_100 <= 1'b0;
			full_duplex <= 1'b0;
		end
		else
		begin
			an_enable <= an_en_q;
			speed_100 <= eff_speed;
			full_duplex <= eff_duplex;
		end
	end

	// Register block stays alive; only the port is powered down
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			power_down <= basic_mode_pkg::RST_POWER_DOWN;
		else
			power_down <= eff_pd;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			isolate <= basic_mode_pkg::RST_ISOLATE;
		else
			isolate <= iso_q;
	end

	col_test_gen u_col (
		.clk(pclk),
		.rst_n(presetn),
		.test_en(col_test_q & ~eff_pd),
		.tx_en(txen_sync),
		.col(col_raw)
	);

	// Collision is not driven toward an isolated MAC
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			col <= 1'b0;
		else
			col <= col_raw & ~iso_q;
	end

	// At 10 Mb/s link is always required
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_allowed <= 1'b0;
		else
			tx_allowed <= ~eff_pd &
				(link_sync | (unidir_q & eff_speed));
	end
endmodule : basic_mode_control

//--- basic_mode_monitor.sv
/* Checker for the basic mode control block ports.
 Assumes it is bound onto basic_mode_control. */
`timescale 1ns/1ps
module basic_mode_monitor (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	// Pins
	input wire logic power_down_pin_n,
	input wire logic tx_en,
	// Mode outputs
	input wire logic col,
	input wire logic power_down,
	input wire logic tx_allowed,
	input wire logic an_restart_req,
	input wire logic an_enable
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
AST_READY_ONE: assert property (pready |=> !pready)
	else $error("pready longer than one cycle");
AST_READY_SOON: assert property (psel && penable |-> ##[0:40] pready)
	else $error("no bus answer");
AST_RSVD: assert property (pready && !pwrite |->
	prdata[31:16] == 16'h0000 && prdata[6] == 1'b0 && prdata[4:0] == 5'h00)
	else $error("reserved bits");
AST_UNMAPPED: assert property (pready && paddr != 12'h000 |-> pslverr
	&& (pwrite || prdata == 32'h0000_0000)) else $error("unmapped access");
AST_RESTART_ONE: assert property (an_restart_req |=> !an_restart_req)
	else $error("restart request too long");
AST_RESTART_AN: assert property (an_restart_req |-> ##[0:2] an_enable)
	else $error("restart with negotiation off");
AST_PIN_PD: assert property (!power_down_pin_n [*6] |-> power_down)
	else $error("pin does not power down");
AST_COL_DROP: assert property (!tx_en [*5] |-> !col)
	else $error("collision held too long");
AST_PD_TX: assert property (power_down [*2] |-> !tx_allowed)
	else $error("transmit while powered down");
cover property (col);
cover property (an_restart_req);
cover property (pready && pslverr);
endmodule : basic_mode_monitor
bind basic_mode_control basic_mode_monitor u_basic_mode_monitor (.*);

//--- an_partner.sv
/* Negotiation logic model: answers a start request after a delay.
 Assumes the request pulse is on pclk. */
`timescale 1ns/1ps
module an_partner (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Handshake
	input wire logic an_restart_req,
	input wire logic [7:0] delay,
	output logic an_started
);
logic busy_q;
logic [7:0] cnt_q;
always_ff @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		busy_q <= 1'b0;
		cnt_q <= 8'h00;
		an_started <= 1'b0;
	end
	else
	begin
		an_started <= busy_q && cnt_q == 8'h00;
		if (an_restart_req)
		begin
			busy_q <= 1'b1;
			cnt_q <= delay;
		end
		else if (busy_q)
		begin
			busy_q <= cnt_q != 8'h00;
			cnt_q <= cnt_q - 8'h01;
		end
	end
end
endmodule : an_partner

//--- phy_basic_mode_control_bench.sv
/* Self-checking bench for basic_mode_control.
 Assumes an_partner and the bound checker are compiled. */
`timescale 1ns/1ps
module phy_basic_mode_control_bench;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0000_004F;
logic pslverr, er, s_an = 1, s_sp = 1, s_fd = 0, fib = 0, pd_n = 1;
logic tx_en = 0, link_up = 0, a_sp = 0, a_fd = 0, an_started, req, an_en;
logic sp, fd, pd, iso, col, txa;
logic [7:0] delay = 8'd20;
logic [15:0] w;
int fail_count = 0, comparisons = 0, pulses = 0, p0, n;
int starts = 0, s0;
always #5 pclk = ~pclk;
always @(posedge pclk) if (req === 1'b1) pulses++;
// Negotiation starts seen, to show a clear does not cancel one
always @(posedge pclk) if (an_started === 1'b1) starts++;
basic_mode_control u_basic_mode_control (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.strap_an_enable(s_an), .strap_speed_100(s_sp), .strap_full_duplex(s_fd),
	.fiber_mode_enable(fib), .power_down_pin_n(pd_n), .tx_en(tx_en),
	.link_up(link_up), .an_started(an_started), .an_speed_100(a_sp),
	.an_full_duplex(a_fd), .an_restart_req(req), .an_enable(an_en),
	.speed_100(sp), .full_duplex(fd), .power_down(pd), .isolate(iso),
	.col(col), .tx_allowed(txa));
an_partner u_an_partner (.pclk(pclk), .presetn(presetn),
	.an_restart_req(req), .delay(delay), .an_started(an_started));
function automatic logic [31:0] xs(logic [31:0] s);
	s ^= s << 13;
	s ^= s >> 17;
	s ^= s << 5;
	return s;
endfunction : xs
// Expected speed, duplex, transmit permission for a written word
function automatic logic [2:0] mode(logic [15:0] v, logic lk);
	logic s;
	s = v[12] ? a_sp : v[13];
	return {s, v[12] ? a_fd : v[8], !v[11] & (lk | (v[5] & s))};
endfunction : mode
task test_done;
	$display("checks %0d errors %0d", comparisons, fail_count);
	if (fail_count == 0 && comparisons > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask : test_done
task chk(input logic [31:0] got, input logic [31:0] exp);
	comparisons++;
	if (got !== exp)
	begin
		fail_count++;
		$display("[ERR] %0t got %h want %h", $time, got, exp);
	end
endtask : chk
// Called right after a rising edge; returns one edge after release
task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
	psel <= 1;
	pwrite <= wr;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1;
	n = 0;
	do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
	rd = prdata;
	er = pslverr;
	if (pready !== 1'b1)
	begin
		chk(0, 1);
		test_done();
	end
	psel <= 0;
	penable <= 0;
	@(posedge pclk);
endtask : apb
task rst;
	presetn <= 0;
	repeat (3) @(posedge pclk);
	presetn <= 1;
	@(posedge pclk);
endtask : rst
initial
begin
	rst();
	apb(0, 12'h000, 0); chk(rd, 32'h3000);
	fib <= 1; rst(); apb(0, 12'h000, 0); chk(rd, 32'h2000);
	fib <= 0;
	apb(0, 12'h004, 0); chk(er, 1);
	chk(rd, 32'h0);
	apb(1, 12'h004, 32'hFFFF); apb(0, 12'h000, 0); chk(rd, 32'h2000);
	repeat (24)
	begin
		seed = xs(seed);
		w = seed[15:0] & 16'hFDFF;
		link_up <= seed[16]; a_sp <= seed[17]; a_fd <= seed[18];
		apb(1, 12'h000, {seed[31:16], w});
		repeat (5) @(posedge pclk);
		apb(0, 12'h000, 0); chk(rd, {16'h0, w & 16'h3DA0});
		chk({sp, fd, txa}, mode(w, link_up));
		chk({pd, iso, an_en, col}, {w[11:10], w[12], 1'b0});
	end
	p0 = pulses;
	s0 = starts;
	apb(1, 12'h000, 32'h1200); apb(1, 12'h000, 32'h1200);
	apb(0, 12'h000, 0); chk(rd, 32'h1200);
	apb(1, 12'h000, 32'h1000); repeat (30) @(posedge pclk);
	apb(0, 12'h000, 0); chk(rd, 32'h1000);
	chk(pulses - p0, 1);
	chk(starts - s0, 1);
	apb(1, 12'h000, 32'h0200); repeat (30) @(posedge pclk);
	apb(0, 12'h000, 0); chk(rd, 32'h0);
	chk(pulses - p0, 1);
	apb(1, 12'h000, 32'h0080);
	tx_en <= 1; n = 0;
	do begin @(posedge pclk); n++; end
	while (col !== 1'b1 && n < basic_mode_pkg::COL_ASSERT_MAX_CYCLES);
	chk(col, 1);
	tx_en <= 0; repeat (5) @(posedge pclk); chk(col, 0);
	pd_n <= 0; repeat (6) @(posedge pclk);
	apb(0, 12'h000, 0); chk({pd, rd[11]}, 2'b11);
	test_done();
end
endmodule : phy_basic_mode_control_bench
